// *** design/fhtc_ctrl.sv ***
`timescale 1ns/1ps
module fhtc_ctrl #(
  parameter logic [fhtc_pkg::TMR_W-1:0] SPACING_CYC = fhtc_pkg::SPACING_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [fhtc_pkg::ADDR_W-1:0] PADDR,
  input wire logic [fhtc_pkg::DATA_W-1:0] PWDATA,
  output logic [fhtc_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  fhtc_link_if.ctrl LINK
);
  import fhtc_pkg::*;

  localparam int SG = 0;
  localparam int SA = 1;
  localparam int SS = 2;
  localparam int SR = 3;

  typedef enum logic [1:0] {
    FHTC_IDLE,
    FHTC_SETUP,
    FHTC_PULSE,
    FHTC_LEAD
  } fhtc_ctl_state_e;

  typedef struct packed {
    fhtc_ctl_state_e state;
    fhtc_cmd_e kind;
    logic [SEL_W-1:0] sel;
    logic [TMR_W-1:0] cnt;
    logic [3:0][TMR_W-1:0] since;
    logic gen;
    logic ana;
    logic step;
    logic rst_n;
    logic supp_n;
    logic [DATA_W-1:0] prdata;
  } fhtc_ctl_s;

  fhtc_ctl_s r;
  fhtc_ctl_s n;
  logic mapped;
  logic cmd_wr;
  logic space_ok;

  assign mapped = (PADDR == CMD_OFS) || (PADDR == STAT_OFS) || (PADDR == SUPP_OFS);
  assign cmd_wr = PSEL && PENABLE && PWRITE && (PADDR == CMD_OFS);
  // a command write stalls until the previous command has finished
  assign PREADY = !(cmd_wr && (r.state != FHTC_IDLE));
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign PRDATA = r.prdata;

  always_comb begin
    n = r;
    space_ok = 1'b0;
    // gaps saturate at all ones so every threshold stays reachable
    for (int i = 0; i < 4; i++) begin
      if (r.since[i] != '1) begin
        n.since[i] = r.since[i] + 1'b1;
      end
    end
    // read data captured in the setup cycle
    if (PSEL && !PENABLE) begin
      n.prdata = '0;
      if (PADDR == CMD_OFS) begin
        n.prdata[CMD_KIND_LSB +: 3] = r.kind;
        n.prdata[CMD_SEL_LSB +: SEL_W] = r.sel;
      end else if (PADDR == STAT_OFS) begin
        n.prdata[STAT_BUSY_BIT] = (r.state != FHTC_IDLE);
      end else if (PADDR == SUPP_OFS) begin
        n.prdata[SUPP_ON_BIT] = !r.supp_n;
      end
    end
    if (PSEL && PENABLE && PWRITE && PADDR == SUPP_OFS) begin
      n.supp_n = !PWDATA[SUPP_ON_BIT];
    end
    unique case (r.kind)
      FHTC_CMD_GEN: space_ok = r.since[SG] >= SPACING_CYC;
      FHTC_CMD_ANA: space_ok = r.since[SA] >= SPACING_CYC;
      FHTC_CMD_BOTH: space_ok = r.since[SA] >= SPACING_CYC && r.since[SG] >= SPACING_CYC;
      FHTC_CMD_STEP: space_ok = r.since[SS] >= SPACING_CYC
        && r.since[SR] >= STEP_AFTER_RST_CYC;
      FHTC_CMD_RST: space_ok = r.since[SS] >= RST_AFTER_STEP_CYC;
      default: space_ok = 1'b0;
    endcase
    unique case (r.state)
      FHTC_IDLE: begin
        if (cmd_wr) begin
          n.kind = fhtc_cmd_e'(PWDATA[CMD_KIND_LSB +: 3]);
          n.sel = PWDATA[CMD_SEL_LSB +: SEL_W];
          n.cnt = '0;
          if (PWDATA[CMD_KIND_LSB +: 3] inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5}) begin
            n.state = FHTC_SETUP;
          end
        end
      end
      FHTC_SETUP: begin
        if (r.cnt < SEL_STABLE_CYC) begin
          n.cnt = r.cnt + 1'b1;
        end
        if (r.cnt >= SEL_STABLE_CYC - 1'b1 && space_ok) begin
          n.state = FHTC_PULSE;
          n.cnt = '0;
          unique case (r.kind)
            FHTC_CMD_GEN: begin
              n.gen = 1'b1;
              n.since[SG] = '0;
            end
            FHTC_CMD_STEP: begin
              n.step = 1'b1;
              n.since[SS] = '0;
            end
            FHTC_CMD_RST: n.rst_n = 1'b0;
            default: begin
              n.ana = 1'b1;
              n.since[SA] = '0;
            end
          endcase
        end
      end
      FHTC_PULSE: begin
        n.cnt = r.cnt + 1'b1;
        if (r.cnt >= PULSE_CYC - 1'b1) begin
          n.gen = 1'b0;
          n.ana = 1'b0;
          n.step = 1'b0;
          n.rst_n = 1'b1;
          if (!r.rst_n) begin
            n.since[SR] = '0;
          end
          n.state = (r.kind == FHTC_CMD_BOTH && r.ana) ? FHTC_LEAD : FHTC_IDLE;
        end
      end
      FHTC_LEAD: begin
        if (r.since[SA] >= ANA_LEAD_CYC && r.since[SG] >= SPACING_CYC) begin
          n.gen = 1'b1;
          n.since[SG] = '0;
          n.cnt = '0;
          n.state = FHTC_PULSE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      r <= '0;
      r.state <= FHTC_IDLE;
      r.kind <= FHTC_CMD_NONE;
      r.since <= '1;
      r.rst_n <= 1'b1;
      r.supp_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign LINK.gen_hop_trigger = r.gen;
  assign LINK.ana_hop_trigger = r.ana;
  assign LINK.seq_step_trigger = r.step;
  assign LINK.seq_reset_request_n = r.rst_n;
  assign LINK.hop_suppress_n = r.supp_n;
  assign LINK.hop_table_select = r.sel;
endmodule

// *** design/fhtc_device.sv ***
// How it works
// - external mode samples select on trigger edge
// - select lines are unsigned binary, high one
// - generator hops only armed, hop mode: on its trigger in external mode, on a step in sequence mode
// - generator takes its table entry per hop
// - analyzer takes its table entry per hop
// - hop ends within single or simultaneous limit
// - same trigger spaced at least 577 us
// - analyzer leading 20-250 us times generator from it
// - generator leading under 250 us times analyzer
// - analyzer trigger leads generator by 10 us
// - generator output pulsed off during hop
// - in sequence mode, same next analyzer frequency means no retune
// - sequence analyzer hop uses simultaneous limit when generator is armed in hop mode
// - accepted reset zeroes counter at next step
// - reset low 1 us, after step 1 us
// - step only 1 us after reset release
// - suppress low advances counter, skips retune
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module fhtc_device #(
  parameter logic [fhtc_pkg::TMR_W-1:0] SINGLE_HOP_CYC = fhtc_pkg::SINGLE_HOP_CYC,
  parameter logic [fhtc_pkg::TMR_W-1:0] SIMUL_HOP_CYC = fhtc_pkg::SIMUL_HOP_CYC,
  parameter logic [fhtc_pkg::TMR_W-1:0] WIN_MAX_CYC = fhtc_pkg::WIN_MAX_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  fhtc_link_if.device LINK,
  input wire logic GEN_HOP_MODE,
  input wire logic GEN_ARMED,
  input wire logic ANA_HOP_MODE,
  input wire logic ANA_ARMED,
  input wire logic ADDR_SRC_EXT,
  input wire logic PULSE_ON_HOP,
  input wire logic TBL_WR,
  input wire logic TBL_WR_ANA,
  input wire logic [fhtc_pkg::SEL_W-1:0] TBL_ADDR,
  input wire logic [fhtc_pkg::FREQ_W-1:0] TBL_DATA,
  output logic [fhtc_pkg::FREQ_W-1:0] GEN_FREQ,
  output logic [fhtc_pkg::FREQ_W-1:0] ANA_FREQ,
  output logic GEN_RF_ON,
  output logic GEN_BUSY,
  output logic ANA_BUSY,
  output logic GEN_DONE,
  output logic ANA_DONE,
  output logic [fhtc_pkg::SEL_W-1:0] SEQ_COUNT
);
  import fhtc_pkg::*;

  localparam int P_GEN = 4;
  localparam int P_ANA = 3;
  localparam int P_STEP = 2;
  localparam int P_RSTN = 1;
  localparam int P_SUPN = 0;

  typedef struct packed {
    logic [SEL_W-1:0] seq_cnt;
    logic [TMR_W-1:0] since_step;
    logic [TMR_W-1:0] rst_low;
    logic rst_ok;
    logic rst_pend;
    logic gen_req;
    logic ana_req;
    logic ana_chk;
    logic [SEL_W-1:0] gen_idx;
    logic [SEL_W-1:0] ana_idx;
    logic [FREQ_W-1:0] gen_freq;
    logic [FREQ_W-1:0] ana_freq;
    logic gen_busy;
    logic ana_busy;
    logic [TMR_W-1:0] gen_cnt;
    logic [TMR_W-1:0] ana_cnt;
    logic gen_simul;
    logic ana_simul;
    logic gen_done;
    logic ana_done;
    logic gen_rf_on;
  } fhtc_dev_s;

  fhtc_dev_s r;
  fhtc_dev_s n;
  logic [FREQ_W-1:0] gen_tbl [TBL_DEPTH];
  logic [FREQ_W-1:0] ana_tbl [TBL_DEPTH];
  logic [4:0] pin_lvl;
  logic [4:0] pin_rise;
  logic [SEL_W-1:0] sel_lvl;
  logic gen_ok;
  logic ana_ok;
  logic seq_step;
  logic seq_go;
  logic gen_go;
  logic ana_go;
  logic rst_set;
  logic [SEL_W-1:0] idx;

  fhtc_sync #(.W(5)) u_pin_sync (
    .CLK(CLK),
    .RST(RST),
    .D({LINK.gen_hop_trigger, LINK.ana_hop_trigger, LINK.seq_step_trigger,
        LINK.seq_reset_request_n, LINK.hop_suppress_n}),
    .Q(pin_lvl),
    .RISE(pin_rise)
  );

  // select passes the same depth as the triggers, so it lines up at the edge
  fhtc_sync #(.W(SEL_W)) u_sel_sync (
    .CLK(CLK),
    .RST(RST),
    .D(LINK.hop_table_select),
    .Q(sel_lvl),
    .RISE()
  );

  // user table loading
  always_ff @(posedge CLK) begin
    if (TBL_WR && !TBL_WR_ANA) begin
      gen_tbl[TBL_ADDR] <= TBL_DATA;
    end
    if (TBL_WR && TBL_WR_ANA) begin
      ana_tbl[TBL_ADDR] <= TBL_DATA;
    end
  end

  assign gen_ok = GEN_HOP_MODE && GEN_ARMED;
  assign ana_ok = ANA_HOP_MODE && ANA_ARMED;
  assign seq_step = !ADDR_SRC_EXT && pin_rise[P_STEP] && (gen_ok || ana_ok);
  assign seq_go = seq_step && pin_lvl[P_SUPN];
  assign gen_go = (ADDR_SRC_EXT && gen_ok && pin_rise[P_GEN]) || (seq_go && gen_ok);
  assign ana_go = (ADDR_SRC_EXT && ana_ok && pin_rise[P_ANA]) || (seq_go && ana_ok);

  always_comb begin
    n = r;
    n.gen_done = 1'b0;
    n.ana_done = 1'b0;
    n.gen_req = 1'b0;
    n.ana_req = 1'b0;
    rst_set = 1'b0;
    idx = '0;
    // hop completion timers
    if (r.gen_busy) begin
      n.gen_cnt = r.gen_cnt + 1'b1;
      if (r.gen_cnt >= (r.gen_simul ? SIMUL_HOP_CYC : SINGLE_HOP_CYC) - 1'b1) begin
        n.gen_busy = 1'b0;
        n.gen_done = 1'b1;
      end
    end
    if (r.ana_busy) begin
      n.ana_cnt = r.ana_cnt + 1'b1;
      if (r.ana_cnt >= (r.ana_simul ? SIMUL_HOP_CYC : SINGLE_HOP_CYC) - 1'b1) begin
        n.ana_busy = 1'b0;
        n.ana_done = 1'b1;
      end
    end
    // retune from the tables one cycle after the start
    if (r.gen_req) begin
      n.gen_freq = gen_tbl[r.gen_idx];
    end
    if (r.ana_req) begin
      if (r.ana_chk && ana_tbl[r.ana_idx] == r.ana_freq) begin
        n.ana_busy = 1'b0;
      end else begin
        n.ana_freq = ana_tbl[r.ana_idx];
      end
    end
    // sequence reset qualification
    if (r.since_step < RST_AFTER_STEP_CYC) begin
      n.since_step = r.since_step + 1'b1;
    end
    if (!pin_lvl[P_RSTN]) begin
      if (r.rst_low == '0) begin
        n.rst_ok = (r.since_step >= RST_AFTER_STEP_CYC);
      end
      if (r.rst_low < PULSE_CYC) begin
        n.rst_low = r.rst_low + 1'b1;
      end
      rst_set = n.rst_ok && (r.rst_low == PULSE_CYC - 1'b1);
    end else begin
      n.rst_low = '0;
    end
    if (rst_set) begin
      n.rst_pend = 1'b1;
    end
    if (seq_step) begin
      n.seq_cnt = (r.rst_pend || rst_set) ? '0 : r.seq_cnt + 1'b1;
      n.rst_pend = 1'b0;
      n.since_step = '0;
    end
    idx = ADDR_SRC_EXT ? sel_lvl : n.seq_cnt;
    if (gen_go) begin
      n.gen_req = 1'b1;
      n.gen_idx = idx;
      n.gen_busy = 1'b1;
      n.gen_cnt = '0;
      n.gen_simul = 1'b0;
      if (ADDR_SRC_EXT && ana_go) begin
        n.gen_simul = 1'b1;
      end else if (ADDR_SRC_EXT && r.ana_busy && r.ana_cnt >= WIN_MIN_CYC
                   && r.ana_cnt < WIN_MAX_CYC) begin
        n.gen_simul = 1'b1;
        n.gen_cnt = n.ana_cnt;
      end
    end
    if (ana_go) begin
      n.ana_req = 1'b1;
      n.ana_idx = idx;
      n.ana_chk = !ADDR_SRC_EXT;
      n.ana_busy = 1'b1;
      n.ana_cnt = '0;
      n.ana_simul = !ADDR_SRC_EXT && gen_ok;
      if (ADDR_SRC_EXT && gen_go) begin
        n.ana_simul = 1'b1;
      end else if (ADDR_SRC_EXT && r.gen_busy && r.gen_cnt < WIN_MAX_CYC) begin
        n.ana_simul = 1'b1;
        n.ana_cnt = n.gen_cnt;
      end
    end
    n.gen_rf_on = !(PULSE_ON_HOP && n.gen_busy);
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      r <= '0;
      r.gen_rf_on <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign GEN_FREQ = r.gen_freq;
  assign ANA_FREQ = r.ana_freq;
  assign GEN_RF_ON = r.gen_rf_on;
  assign GEN_BUSY = r.gen_busy;
  assign ANA_BUSY = r.ana_busy;
  assign GEN_DONE = r.gen_done;
  assign ANA_DONE = r.ana_done;
  assign SEQ_COUNT = r.seq_cnt;
endmodule

// *** design/fhtc_link_if.sv ***
`timescale 1ns/1ps
interface fhtc_link_if;
  logic gen_hop_trigger;
  logic ana_hop_trigger;
  logic seq_step_trigger;
  logic seq_reset_request_n;
  logic hop_suppress_n;
  logic [fhtc_pkg::SEL_W-1:0] hop_table_select;

  modport device (
    input gen_hop_trigger,
    input ana_hop_trigger,
    input seq_step_trigger,
    input seq_reset_request_n,
    input hop_suppress_n,
    input hop_table_select
  );

  modport ctrl (
    output gen_hop_trigger,
    output ana_hop_trigger,
    output seq_step_trigger,
    output seq_reset_request_n,
    output hop_suppress_n,
    output hop_table_select
  );
endinterface

// *** design/fhtc_pkg.sv ***
package fhtc_pkg;
  localparam int CLK_MHZ = 100;
  localparam int SEL_W = 11;
  localparam int FREQ_W = 32;
  localparam int TBL_DEPTH = 2048;
  localparam int TMR_W = 17;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;

  // times in ns
  localparam int SINGLE_HOP_LIMIT_NS = 570000;
  localparam int SIMULTANEOUS_HOP_LIMIT_NS = 850000;
  localparam int TRIGGER_SPACING_MIN_NS = 577000;
  localparam int TRIGGER_SPACING_USEFUL_NS = 1150000;
  localparam int SIMUL_WIN_MIN_NS = 20000;
  localparam int SIMUL_WIN_MAX_NS = 250000;
  localparam int ANA_LEAD_MIN_NS = 10000;
  localparam int MIN_PULSE_WIDTH_NS = 1000;
  localparam int SEL_STABLE_NS = 1000;
  localparam int RST_AFTER_STEP_NS = 1000;
  localparam int STEP_AFTER_RST_NS = 1000;

  function automatic int min_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [TMR_W-1:0] SINGLE_HOP_CYC = TMR_W'(max_cyc(SINGLE_HOP_LIMIT_NS));
  localparam logic [TMR_W-1:0] SIMUL_HOP_CYC = TMR_W'(max_cyc(SIMULTANEOUS_HOP_LIMIT_NS));
  localparam logic [TMR_W-1:0] SPACING_CYC = TMR_W'(min_cyc(TRIGGER_SPACING_MIN_NS));
  localparam logic [TMR_W-1:0] WIN_MIN_CYC = TMR_W'(min_cyc(SIMUL_WIN_MIN_NS));
  localparam logic [TMR_W-1:0] WIN_MAX_CYC = TMR_W'(max_cyc(SIMUL_WIN_MAX_NS));
  localparam logic [TMR_W-1:0] ANA_LEAD_CYC = TMR_W'(min_cyc(ANA_LEAD_MIN_NS));
  localparam logic [TMR_W-1:0] PULSE_CYC = TMR_W'(min_cyc(MIN_PULSE_WIDTH_NS));
  localparam logic [TMR_W-1:0] SEL_STABLE_CYC = TMR_W'(min_cyc(SEL_STABLE_NS));
  localparam logic [TMR_W-1:0] RST_AFTER_STEP_CYC = TMR_W'(min_cyc(RST_AFTER_STEP_NS));
  localparam logic [TMR_W-1:0] STEP_AFTER_RST_CYC = TMR_W'(min_cyc(STEP_AFTER_RST_NS));

  // controller registers
  localparam logic [ADDR_W-1:0] CMD_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] SUPP_OFS = 8'h08;
  localparam int CMD_KIND_LSB = 0;
  localparam int CMD_SEL_LSB = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int SUPP_ON_BIT = 0;

  typedef enum logic [2:0] {
    FHTC_CMD_NONE = 3'h0,
    FHTC_CMD_GEN = 3'h1,
    FHTC_CMD_ANA = 3'h2,
    FHTC_CMD_BOTH = 3'h3,
    FHTC_CMD_STEP = 3'h4,
    FHTC_CMD_RST = 3'h5
  } fhtc_cmd_e;
endpackage

// *** design/fhtc_sync.sv ***
`timescale 1ns/1ps
module fhtc_sync #(
  parameter int W = 1
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q,
  output logic [W-1:0] RISE
);
  typedef struct packed {
    logic [W-1:0] f1;
    logic [W-1:0] f2;
    logic [W-1:0] f3;
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
  } fhtc_sync_s;

  fhtc_sync_s r;
  fhtc_sync_s n;
  logic [W-1:0] agree;

  always_comb begin
    n = r;
    n.f1 = D;
    n.f2 = r.f1;
    n.f3 = r.f2;
    // a change counts once stages two and three agree
    agree = ~(r.f2 ^ r.f3);
    n.lvl = (r.f3 & agree) | (r.lvl & ~agree);
    n.rise = n.lvl & ~r.lvl;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign Q = r.lvl;
  assign RISE = r.rise;
endmodule

// *** verification/fhtc_monitor.sv ***
`timescale 1ns/1ps
module fhtc_monitor
  import fhtc_pkg::*;
#(
  parameter int SPACING = 400,
  parameter int HOP_MAX = 310
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic gen_hop_trigger,
  input wire logic ana_hop_trigger,
  input wire logic seq_step_trigger,
  input wire logic seq_reset_request_n,
  input wire logic hop_suppress_n,
  input wire logic [fhtc_pkg::SEL_W-1:0] hop_table_select,
  input wire logic PULSE_ON_HOP,
  input wire logic GEN_RF_ON,
  input wire logic GEN_BUSY,
  input wire logic ANA_BUSY,
  input wire logic GEN_DONE
);
  localparam int SAT = 100000;
  int gen_hi;
  int gen_since;
  int ana_since;
  int step_since;
  int rel_since;

  function automatic int sat(input int v);
    return (v < SAT) ? v + 1 : v;
  endfunction

  // cycles since each edge, saturating; cycles the generator trigger has been high, not saturating
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      gen_hi <= 0;
      gen_since <= SAT;
      ana_since <= SAT;
      step_since <= SAT;
      rel_since <= SAT;
    end else begin
      gen_hi <= gen_hop_trigger ? gen_hi + 1 : 0;
      gen_since <= $rose(gen_hop_trigger) ? 1 : sat(gen_since);
      ana_since <= $rose(ana_hop_trigger) ? 1 : sat(ana_since);
      step_since <= $rose(seq_step_trigger) ? 1 : sat(step_since);
      rel_since <= $rose(seq_reset_request_n) ? 1 : sat(rel_since);
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  chk_gen_width: assert property ($fell(gen_hop_trigger) |-> gen_hi >= int'(PULSE_CYC))
    else $error("generator trigger pulse too short");
  chk_gen_spacing: assert property ($rose(gen_hop_trigger) |-> gen_since >= SPACING)
    else $error("generator triggers too close");
  chk_ana_lead: assert property (
    $rose(gen_hop_trigger) |-> ana_since >= int'(ANA_LEAD_CYC))
    else $error("analyzer trigger lead too short");
  chk_select_hold: assert property (
    (gen_hop_trigger || ana_hop_trigger) |-> $stable(hop_table_select))
    else $error("select moved around trigger");
  chk_rst_after_step: assert property (
    $fell(seq_reset_request_n) |-> step_since >= int'(RST_AFTER_STEP_CYC))
    else $error("reset request too soon after step");
  chk_step_after_rst: assert property (
    $rose(seq_step_trigger) |-> seq_reset_request_n && rel_since >= int'(STEP_AFTER_RST_CYC))
    else $error("step too soon after reset release");
  chk_rf_pulse_off: assert property (PULSE_ON_HOP && GEN_BUSY |-> !GEN_RF_ON)
    else $error("generator output on during hop");
  chk_gen_hop_bound: assert property ($rose(GEN_BUSY) |-> ##[1:HOP_MAX] !GEN_BUSY)
    else $error("generator hop too long");
  chk_ana_hop_bound: assert property ($rose(ANA_BUSY) |-> ##[1:HOP_MAX] !ANA_BUSY)
    else $error("analyzer hop too long");
  chk_done_at_end: assert property (GEN_DONE |-> !GEN_BUSY && $past(GEN_BUSY))
    else $error("done pulse not at hop end");
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import fhtc_pkg::*;
  logic CLK = 0;
  logic RST = 1;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic gen_mode = 1, gen_arm = 1, ana_mode = 1, ana_arm = 1, ext = 1, pulse = 1;
  logic twr = 0, twa = 0, e, rf_on, gen_busy, ana_busy, gen_done, ana_done;
  logic [10:0] taddr = 11'h000, seq_count;
  logic [31:0] tdata = 32'h0, gen_freq, ana_freq;
  int n_errors = 0, checks = 0, cyc = 0, ana_dones = 0, d;

  fhtc_link_if link();
  fhtc_ctrl #(.SPACING_CYC(17'd400)) i_fhtc_ctrl(.CLK(CLK), .RST(RST), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LINK(link));
  fhtc_device #(.SINGLE_HOP_CYC(17'd200), .SIMUL_HOP_CYC(17'd300)) i_fhtc_device(.CLK(CLK),
    .RST(RST), .LINK(link), .GEN_HOP_MODE(gen_mode), .GEN_ARMED(gen_arm),
    .ANA_HOP_MODE(ana_mode), .ANA_ARMED(ana_arm), .ADDR_SRC_EXT(ext), .PULSE_ON_HOP(pulse),
    .TBL_WR(twr), .TBL_WR_ANA(twa), .TBL_ADDR(taddr), .TBL_DATA(tdata), .GEN_FREQ(gen_freq),
    .ANA_FREQ(ana_freq), .GEN_RF_ON(rf_on), .GEN_BUSY(gen_busy), .ANA_BUSY(ana_busy),
    .GEN_DONE(gen_done), .ANA_DONE(ana_done), .SEQ_COUNT(seq_count));
  fhtc_monitor #(.SPACING(400), .HOP_MAX(310)) i_fhtc_monitor(.CLK(CLK), .RST(RST),
    .gen_hop_trigger(link.gen_hop_trigger), .ana_hop_trigger(link.ana_hop_trigger),
    .seq_step_trigger(link.seq_step_trigger), .seq_reset_request_n(link.seq_reset_request_n),
    .hop_suppress_n(link.hop_suppress_n), .hop_table_select(link.hop_table_select),
    .PULSE_ON_HOP(pulse), .GEN_RF_ON(rf_on), .GEN_BUSY(gen_busy), .ANA_BUSY(ana_busy),
    .GEN_DONE(gen_done));

  always #5 CLK = ~CLK;

  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (ana_done === 1'b1) ana_dones <= ana_dones + 1;
    if (cyc == 60000) begin
      n_errors++;
      test_done();
    end
  end

  task test_done;
    if (n_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [31:0] tv(input logic an, input logic [10:0] a);
    return {an ? 16'h00a0 : 16'h00b0, 5'h00, a};
  endfunction

  // one apb transfer, held until pready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge CLK);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    penable <= 0;
    @(posedge CLK);
    penable <= 1;
    @(posedge CLK);
    while (pready !== 1'b1) @(posedge CLK);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task twrite(input logic an, input logic [10:0] a, input logic [31:0] v);
    @(posedge CLK);
    twr <= 1;
    twa <= an;
    taddr <= a;
    tdata <= v;
    @(posedge CLK);
    twr <= 0;
  endtask

  // command, wait for controller idle and device hop end
  task hop(input logic [2:0] k, input logic [10:0] s);
    apb(1, CMD_OFS, {5'h00, s, 13'h0000, k});
    repeat (2) @(posedge CLK);
    r = 32'h1;
    while (r[0] !== 1'b0) apb(0, STAT_OFS, 32'h0);
    while (gen_busy === 1'b1 || ana_busy === 1'b1) @(posedge CLK);
    // let the done pulse count settle before anyone reads it
    @(posedge CLK);
  endtask

  task seqchk(input logic [10:0] c, input logic [10:0] g, input logic [10:0] a);
    check("seq_count", {21'h0, c}, seq_count);
    check("gen_freq", tv(0, g), gen_freq);
    check("ana_freq", tv(1, a), ana_freq);
  endtask

  initial begin
    repeat (2) @(posedge CLK);
    RST <= 0;
    repeat (5) @(posedge CLK);
    check("rf_on", 32'h1, {31'h0, rf_on});
    for (int i = 0; i < 4; i++) begin
      twrite(0, 11'(i), tv(0, 11'(i)));
      twrite(1, 11'(i), tv(1, 11'(i)));
    end
    twrite(0, 11'h004, tv(0, 11'h004));
    twrite(1, 11'h004, tv(1, 11'h003));
    twrite(0, 11'h401, tv(0, 11'h401));
    twrite(1, 11'h2aa, tv(1, 11'h2aa));
    hop(1, 11'h401);
    check("gen_freq", tv(0, 11'h401), gen_freq);
    apb(0, CMD_OFS, 32'h0);
    check("cmd", {5'h00, 11'h401, 13'h0000, 3'h1}, r);
    hop(2, 11'h2aa);
    check("ana_freq", tv(1, 11'h2aa), ana_freq);
    hop(3, 11'h002);
    check("gen_freq", tv(0, 11'h002), gen_freq);
    check("ana_freq", tv(1, 11'h002), ana_freq);
    gen_arm <= 0;
    hop(1, 11'h001);
    check("gen_freq", tv(0, 11'h002), gen_freq);
    gen_arm <= 1;
    ext <= 0;
    hop(1, 11'h003);
    check("gen_freq", tv(0, 11'h002), gen_freq);
    hop(4, 11'h000);
    seqchk(11'h001, 11'h001, 11'h001);
    hop(4, 11'h000);
    hop(5, 11'h000);
    hop(4, 11'h000);
    seqchk(11'h000, 11'h000, 11'h000);
    hop(4, 11'h000);
    apb(1, SUPP_OFS, 32'h1);
    apb(0, SUPP_OFS, 32'h0);
    check("supp", 32'h1, r);
    hop(4, 11'h000);
    seqchk(11'h002, 11'h001, 11'h001);
    apb(1, SUPP_OFS, 32'h0);
    hop(4, 11'h000);
    seqchk(11'h003, 11'h003, 11'h003);
    d = ana_dones;
    hop(4, 11'h000);
    seqchk(11'h004, 11'h004, 11'h003);
    check("ana_dones", d, ana_dones);
    hop(5, 11'h000);
    // second step command stalls on pready until the first has finished
    apb(1, CMD_OFS, 32'h4);
    apb(1, CMD_OFS, 32'h4);
    hop(0, 11'h000);
    seqchk(11'h001, 11'h001, 11'h001);
    apb(0, 8'h0c, 32'h0);
    check("pslverr", 32'h1, {31'h0, e});
    test_done();
  end
endmodule
